/* File: rtl/peq_event_qualifier.sv */
// Event qualifier and channel counters for the performance-measurement unit.
`timescale 1ns/1ps
module peq_event_qualifier (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic sys_clk_i,
  input wire logic sys_rst_link_i,
  input wire peq_pkg::peq_operand_s operand_i,
  input wire peq_pkg::peq_sysbus_s sysbus_i,
  input wire logic [peq_pkg::SEL_WIDTH-1:0] chan_sel_i [peq_pkg::CHAN_COUNT],
  input wire logic extend_low_pair_i,
  input wire logic extend_high_pair_i,
  input wire logic count_enable_i,
  input wire logic count_clear_i,
  output logic [peq_pkg::COUNT_WIDTH-1:0] count_o [peq_pkg::CHAN_COUNT],
  output logic [peq_pkg::CHAN_COUNT-1:0] event_pulse_o
);

  // ****************************************
  // Operand event decode
  // ****************************************
  // Operand side inputs come from the core on this same clock.
  logic xy_read_ev;
  logic xy_write_ev;
  logic il_access_ev;
  logic rd_miss_ev;
  logic wr_miss_ev;
  logic rd_wait_ev;
  logic wr_wait_ev;
  logic rd_miss_wait_ev;
  logic wr_miss_wait_ev;
  logic il_rd_wait_ev;
  logic il_wr_wait_ev;
  logic paired_xy;
  logic op_rd;
  logic op_wr;

  always_comb begin
    paired_xy = operand_i.x_transfer_instruction &
      operand_i.y_transfer_instruction;
    op_rd = operand_i.op_bus_valid & ~operand_i.op_bus_write;
    op_wr = operand_i.op_bus_valid & operand_i.op_bus_write;
    // A paired transfer adds one count to each XY access event, never two.
    if (paired_xy) begin
      xy_read_ev = 1'b1;
      xy_write_ev = 1'b1;
    end else begin
      xy_read_ev = operand_i.xy_bus_read |
        (op_rd & operand_i.op_bus_xymem);
      xy_write_ev = operand_i.xy_bus_write |
        (op_wr & operand_i.op_bus_xymem);
    end
    il_access_ev = operand_i.op_bus_valid & operand_i.op_bus_ilmem;
    rd_miss_ev = op_rd & operand_i.cache_miss &
      ~operand_i.cache_preload_instruction;
    wr_miss_ev = op_wr & operand_i.cache_miss &
      ~operand_i.write_through &
      ~operand_i.cache_preload_instruction;
    rd_wait_ev = op_rd & operand_i.op_bus_wait;
    wr_wait_ev = op_wr & operand_i.op_bus_wait;
    rd_miss_wait_ev = (op_rd & operand_i.miss_wait &
      ~operand_i.cache_preload_instruction) | operand_i.fill_wait;
    wr_miss_wait_ev = op_wr & operand_i.miss_wait &
      ~operand_i.write_through;
    il_rd_wait_ev = op_rd & operand_i.op_bus_ilmem &
      operand_i.op_bus_wait;
    il_wr_wait_ev = op_wr & operand_i.op_bus_ilmem &
      operand_i.op_bus_wait;
  end

  // ****************************************
  // System bus events and crossing
  // ****************************************
  peq_pkg::peq_sys_toggle_s sys_tog;
  peq_pkg::peq_sys_toggle_s tog_meta;
  peq_pkg::peq_sys_toggle_s tog_sync;
  peq_pkg::peq_sys_toggle_s tog_seen;
  peq_pkg::peq_sys_toggle_s next_tog_meta;
  peq_pkg::peq_sys_toggle_s next_tog_sync;
  peq_pkg::peq_sys_toggle_s next_tog_seen;
  logic ask_ev;
  logic reply_ev;
  logic ask_stall_ev;
  logic reply_stall_ev;

  peq_sysbus_events u_sysbus_events (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_link_i),
    .bus_i(sysbus_i),
    .toggles_o(sys_tog)
  );

  // Toggles survive the crossing as the bus clock is slower than this one.
  always_comb begin
    next_tog_meta = sys_tog;
    next_tog_sync = tog_meta;
    next_tog_seen = tog_sync;
    ask_ev = tog_sync.ask_toggle ^ tog_seen.ask_toggle;
    reply_ev = tog_sync.reply_toggle ^ tog_seen.reply_toggle;
    ask_stall_ev = tog_sync.ask_stall_toggle ^
      tog_seen.ask_stall_toggle;
    reply_stall_ev = tog_sync.reply_stall_toggle ^
      tog_seen.reply_stall_toggle;
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tog_meta <= '0;
      tog_sync <= '0;
      tog_seen <= '0;
    end else begin
      tog_meta <= next_tog_meta;
      tog_sync <= next_tog_sync;
      tog_seen <= next_tog_seen;
    end
  end

  // ****************************************
  // Channel event selection
  // ****************************************
  logic [peq_pkg::CHAN_COUNT-1:0] chan_ev;
  logic [peq_pkg::CHAN_COUNT-1:0] next_pulse;
  logic [peq_pkg::CHAN_COUNT-1:0] pulse;

  genvar ch;
  generate
    for (ch = 0; ch < peq_pkg::CHAN_COUNT; ch++) begin : g_sel
      localparam logic sys_ok = (ch == int'(peq_pkg::SYS_CHAN_LO)) ||
        (ch == int'(peq_pkg::SYS_CHAN_HI));
      always_comb begin
        chan_ev[ch] = 1'b0;
        case (chan_sel_i[ch])
          peq_pkg::SEL_XYMEM_READ: chan_ev[ch] = xy_read_ev;
          peq_pkg::SEL_XYMEM_WRITE: chan_ev[ch] = xy_write_ev;
          peq_pkg::SEL_ILMEM_ACCESS: chan_ev[ch] = il_access_ev;
          peq_pkg::SEL_CACHE_READ_MISS: chan_ev[ch] = rd_miss_ev;
          peq_pkg::SEL_CACHE_WRITE_MISS: chan_ev[ch] = wr_miss_ev;
          peq_pkg::SEL_OPERAND_READ_WAIT: chan_ev[ch] = rd_wait_ev;
          peq_pkg::SEL_OPERAND_WRITE_WAIT: chan_ev[ch] = wr_wait_ev;
          peq_pkg::SEL_READ_MISS_WAIT: chan_ev[ch] = rd_miss_wait_ev;
          peq_pkg::SEL_WRITE_MISS_WAIT: chan_ev[ch] = wr_miss_wait_ev;
          peq_pkg::SEL_ILMEM_READ_WAIT: chan_ev[ch] = il_rd_wait_ev;
          peq_pkg::SEL_ILMEM_WRITE_WAIT: chan_ev[ch] = il_wr_wait_ev;
          peq_pkg::SEL_SYSBUS_ASK: chan_ev[ch] = sys_ok & ask_ev;
          peq_pkg::SEL_SYSBUS_REPLY: chan_ev[ch] = sys_ok & reply_ev;
          peq_pkg::SEL_ASK_STALL: begin
            chan_ev[ch] = sys_ok & ask_stall_ev;
          end
          peq_pkg::SEL_REPLY_STALL: begin
            chan_ev[ch] = sys_ok & reply_stall_ev;
          end
          default: chan_ev[ch] = 1'b0;
        endcase
        next_pulse[ch] = count_enable_i & chan_ev[ch];
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pulse <= '0;
    end else begin
      pulse <= next_pulse;
    end
  end

  // ****************************************
  // Channel counters
  // ****************************************
  // Counters sit on the CPU clock, so they freeze whenever it is gated.
  logic [peq_pkg::COUNT_WIDTH-1:0] cnt [peq_pkg::CHAN_COUNT];
  logic [peq_pkg::COUNT_WIDTH-1:0] next_cnt [peq_pkg::CHAN_COUNT];
  logic [peq_pkg::CHAN_COUNT-1:0] carry;
  logic [peq_pkg::CHAN_COUNT-1:0] bump;

  // Upper counter of an extended pair takes the carry of the lower one.
  always_comb begin
    for (int i = 0; i < int'(peq_pkg::CHAN_COUNT); i++) begin
      carry[i] = pulse[i] & (&cnt[i]);
    end
    bump[0] = pulse[0];
    bump[1] = extend_low_pair_i ? carry[0] : pulse[1];
    bump[2] = pulse[2];
    bump[3] = extend_high_pair_i ? carry[2] : pulse[3];
    for (int i = 0; i < int'(peq_pkg::CHAN_COUNT); i++) begin
      if (count_clear_i) begin
        next_cnt[i] = peq_pkg::COUNT_RESET;
      end else if (bump[i]) begin
        next_cnt[i] = cnt[i] + peq_pkg::COUNT_ONE;
      end else begin
        next_cnt[i] = cnt[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < int'(peq_pkg::CHAN_COUNT); i++) begin
        cnt[i] <= peq_pkg::COUNT_RESET;
      end
    end else begin
      for (int i = 0; i < int'(peq_pkg::CHAN_COUNT); i++) begin
        cnt[i] <= next_cnt[i];
      end
    end
  end

  assign count_o = cnt;
  assign event_pulse_o = pulse;

endmodule // peq_event_qualifier

/* File: rtl/peq_pkg.sv */
// Package of event codes, channel numbers and carriers for the event qualifier.
package peq_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned CHAN_COUNT = 4;
  localparam int unsigned SEL_WIDTH = 5;
  localparam int unsigned COUNT_WIDTH = 32;
  localparam int unsigned WIDE_WIDTH = 64;
  localparam logic [1:0] SYS_CHAN_LO = 2'h2;
  localparam logic [1:0] SYS_CHAN_HI = 2'h3;
  localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [COUNT_WIDTH-1:0] COUNT_ONE = 32'h0000_0001;

  // ****************************************
  // Event selection codes
  // ****************************************
  localparam logic [SEL_WIDTH-1:0] SEL_NONE = 5'h00;
  localparam logic [SEL_WIDTH-1:0] SEL_XYMEM_READ = 5'h01;
  localparam logic [SEL_WIDTH-1:0] SEL_XYMEM_WRITE = 5'h02;
  localparam logic [SEL_WIDTH-1:0] SEL_ILMEM_ACCESS = 5'h03;
  localparam logic [SEL_WIDTH-1:0] SEL_CACHE_READ_MISS = 5'h04;
  localparam logic [SEL_WIDTH-1:0] SEL_CACHE_WRITE_MISS = 5'h05;
  localparam logic [SEL_WIDTH-1:0] SEL_OPERAND_READ_WAIT = 5'h06;
  localparam logic [SEL_WIDTH-1:0] SEL_OPERAND_WRITE_WAIT = 5'h07;
  localparam logic [SEL_WIDTH-1:0] SEL_READ_MISS_WAIT = 5'h08;
  localparam logic [SEL_WIDTH-1:0] SEL_WRITE_MISS_WAIT = 5'h09;
  localparam logic [SEL_WIDTH-1:0] SEL_ILMEM_READ_WAIT = 5'h0A;
  localparam logic [SEL_WIDTH-1:0] SEL_ILMEM_WRITE_WAIT = 5'h0B;
  localparam logic [SEL_WIDTH-1:0] SEL_SYSBUS_ASK = 5'h0C;
  localparam logic [SEL_WIDTH-1:0] SEL_SYSBUS_REPLY = 5'h0D;
  localparam logic [SEL_WIDTH-1:0] SEL_ASK_STALL = 5'h0E;
  localparam logic [SEL_WIDTH-1:0] SEL_REPLY_STALL = 5'h0F;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic xy_bus_read;
    logic xy_bus_write;
    logic x_transfer_instruction;
    logic y_transfer_instruction;
    logic op_bus_valid;
    logic op_bus_write;
    logic op_bus_xymem;
    logic op_bus_ilmem;
    logic op_bus_wait;
    logic cache_miss;
    logic cache_preload_instruction;
    logic write_through;
    logic miss_wait;
    logic fill_wait;
  } peq_operand_s;

  typedef struct packed {
    logic ask;
    logic ask_accept;
    logic reply;
    logic reply_accept;
  } peq_sysbus_s;

  typedef struct packed {
    logic ask_toggle;
    logic reply_toggle;
    logic ask_stall_toggle;
    logic reply_stall_toggle;
  } peq_sys_toggle_s;

endpackage

/* File: rtl/peq_sysbus_events.sv */
// System bus event detector on the bus clock, passing events as toggles.
`timescale 1ns/1ps
module peq_sysbus_events (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire peq_pkg::peq_sysbus_s bus_i,
  output peq_pkg::peq_sys_toggle_s toggles_o
);

  peq_pkg::peq_sys_toggle_s tog;
  peq_pkg::peq_sys_toggle_s next_tog;

  // ****************************************
  // Event toggles
  // ****************************************
  // One toggle per bus cycle: a waiting ask and a waiting reply each flip their own stall line.
  always_comb begin
    next_tog = tog;
    next_tog.ask_toggle = tog.ask_toggle ^
      (bus_i.ask & bus_i.ask_accept);
    next_tog.reply_toggle = tog.reply_toggle ^
      (bus_i.reply & bus_i.reply_accept);
    next_tog.ask_stall_toggle = tog.ask_stall_toggle ^
      (bus_i.ask & ~bus_i.ask_accept);
    next_tog.reply_stall_toggle = tog.reply_stall_toggle ^
      (bus_i.reply & ~bus_i.reply_accept);
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tog <= '0;
    end else begin
      tog <= next_tog;
    end
  end

  assign toggles_o = tog;

endmodule // peq_sysbus_events

/* File: tb/peq_bus_model.sv */
// Model of the system bus handshakes watched by the event qualifier.
`timescale 1ns/1ps
module peq_bus_model (
  input wire logic sys_clk_i,
  input wire logic run_i,
  output peq_pkg::peq_sysbus_s bus_o,
  output int n_cell [2],
  output int n_stall [2]
);
  initial bus_o = '0;
  // A request stays up until accepted, so stalls come in random runs.
  always @(posedge sys_clk_i) begin
    n_cell[0] += bus_o.ask && bus_o.ask_accept;
    n_stall[0] += bus_o.ask && !bus_o.ask_accept;
    n_cell[1] += bus_o.reply && bus_o.reply_accept;
    n_stall[1] += bus_o.reply && !bus_o.reply_accept;
    #1;
    if (!bus_o.ask || bus_o.ask_accept) begin
      bus_o.ask = run_i && $urandom_range(1);
    end
    if (!bus_o.reply || bus_o.reply_accept) begin
      bus_o.reply = run_i && $urandom_range(1);
    end
    bus_o.ask_accept = 1'($urandom_range(1));
    bus_o.reply_accept = 1'($urandom_range(1));
  end
endmodule // peq_bus_model

/* File: tb/peq_event_qualifier_properties.sv */
// Checker of the event qualifier's port behaviour.
`timescale 1ns/1ps
module peq_qualifier_props (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire peq_pkg::peq_operand_s operand_i,
  input wire logic [peq_pkg::SEL_WIDTH-1:0] chan_sel_i [peq_pkg::CHAN_COUNT],
  input wire logic extend_low_pair_i,
  input wire logic count_enable_i,
  input wire logic count_clear_i,
  input wire logic [peq_pkg::COUNT_WIDTH-1:0] count_o [peq_pkg::CHAN_COUNT],
  input wire logic [peq_pkg::CHAN_COUNT-1:0] event_pulse_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic go;
  logic pair;
  logic wr;
  assign go = count_enable_i && !count_clear_i;
  assign pair = operand_i.x_transfer_instruction &&
    operand_i.y_transfer_instruction;
  assign wr = operand_i.op_bus_valid && operand_i.op_bus_write;
  a_xy_read_pulse: assert property (go && operand_i.xy_bus_read &&
    chan_sel_i[0] == peq_pkg::SEL_XYMEM_READ |=> event_pulse_o[0])
    else $error("read access event missed");
  a_xy_write_pulse: assert property (go && wr && !pair &&
    operand_i.op_bus_xymem && chan_sel_i[1] == peq_pkg::SEL_XYMEM_WRITE
    |=> event_pulse_o[1]) else $error("write access event missed");
  a_pair_write_once: assert property (go && pair &&
    chan_sel_i[1] == peq_pkg::SEL_XYMEM_WRITE |=> event_pulse_o[1])
    else $error("paired transfer missed on write select");
  a_ilmem_pulse: assert property (go && operand_i.op_bus_valid &&
    operand_i.op_bus_ilmem && chan_sel_i[2] == peq_pkg::SEL_ILMEM_ACCESS
    |=> event_pulse_o[2]) else $error("ilmem access missed");
  a_preload_quiet: assert property (
    operand_i.cache_preload_instruction &&
    chan_sel_i[3] == peq_pkg::SEL_CACHE_READ_MISS |=> !event_pulse_o[3])
    else $error("preload miss counted");
  a_through_quiet: assert property (operand_i.write_through &&
    chan_sel_i[3] == peq_pkg::SEL_CACHE_WRITE_MISS |=> !event_pulse_o[3])
    else $error("write-through counted as miss");
  a_bus_code_refused: assert property (
    (chan_sel_i[0] >= peq_pkg::SEL_SYSBUS_ASK)[*2] |-> !event_pulse_o[0])
    else $error("bus event on low channel");
  a_count_step: assert property (!count_clear_i |=> count_o[0] ==
    $past(count_o[0]) + 32'($past(event_pulse_o[0])))
    else $error("counter step wrong");
  a_wide_high_hold: assert property (
    extend_low_pair_i && !count_clear_i &&
    !(event_pulse_o[0] && &count_o[0]) |=> $stable(count_o[1]))
    else $error("high half moved without carry");
  c_bus_pulse: cover property (chan_sel_i[2] == peq_pkg::SEL_SYSBUS_ASK &&
    event_pulse_o[2]);
  c_stall_pulse: cover property (event_pulse_o[3] &&
    chan_sel_i[3] == peq_pkg::SEL_ASK_STALL);
  c_clear: cover property (count_clear_i);
endmodule // peq_qualifier_props

/* File: tb/tb_perf_event_qualifier.sv */
// Self-checking bench for the event qualifier.
`timescale 1ns/1ps
module tb_perf_event_qualifier;
  logic ref_clk = 1'b0;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic rst_link = 1'b1;
  logic run = 1'b0;
  logic en = 1'b0;
  logic clr = 1'b0;
  logic ext = 1'b0;
  peq_pkg::peq_operand_s op = '0;
  peq_pkg::peq_sysbus_s bus;
  logic [4:0] sel [4] = '{default: '0};
  logic [31:0] cnt [4];
  logic [31:0] want [4];
  logic [3:0] pulse;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;
  int n_cell [2];
  int n_stall [2];
  localparam logic [13:0] CORNER [4] = '{14'h3C00, 14'h0218, 14'h0314,
    14'h0360};
  initial forever #20 ref_clk = ~ref_clk;
  initial begin #7; forever #80 sys_clk = ~sys_clk; end
  peq_event_qualifier dut_u (.ref_clk_i(ref_clk), .sys_rst_i(rst),
    .sys_clk_i(sys_clk), .sys_rst_link_i(rst_link), .operand_i(op),
    .sysbus_i(bus), .chan_sel_i(sel), .extend_low_pair_i(ext),
    .extend_high_pair_i(ext), .count_enable_i(en), .count_clear_i(clr),
    .count_o(cnt), .event_pulse_o(pulse));
  peq_bus_model bus_u (.sys_clk_i(sys_clk), .run_i(run), .bus_o(bus),
    .n_cell(n_cell), .n_stall(n_stall));
  function automatic logic ev(input logic [4:0] c,
    input peq_pkg::peq_operand_s o);
    logic p;
    logic r;
    logic w;
    logic m;
    logic x;
    logic y;
    logic i;
    logic t;
    logic v;
    logic mw;
    p = o.x_transfer_instruction && o.y_transfer_instruction;
    r = o.op_bus_valid && !o.op_bus_write;
    w = o.op_bus_valid && o.op_bus_write;
    m = o.cache_miss && !o.cache_preload_instruction;
    x = p || o.xy_bus_read || r && o.op_bus_xymem;
    y = p || o.xy_bus_write || w && o.op_bus_xymem;
    i = o.op_bus_valid && o.op_bus_ilmem;
    t = o.op_bus_wait;
    v = !o.write_through;
    mw = o.miss_wait;
    case (c)
      peq_pkg::SEL_XYMEM_READ: return x;
      peq_pkg::SEL_XYMEM_WRITE: return y;
      peq_pkg::SEL_ILMEM_ACCESS: return i;
      peq_pkg::SEL_CACHE_READ_MISS: return r && m;
      peq_pkg::SEL_CACHE_WRITE_MISS: return w && m && v;
      peq_pkg::SEL_OPERAND_READ_WAIT: return r && t;
      peq_pkg::SEL_OPERAND_WRITE_WAIT: return w && t;
      peq_pkg::SEL_READ_MISS_WAIT: return r && mw || o.fill_wait;
      peq_pkg::SEL_WRITE_MISS_WAIT: return w && mw && v;
      peq_pkg::SEL_ILMEM_READ_WAIT: return r && i && t;
      peq_pkg::SEL_ILMEM_WRITE_WAIT: return w && i && t;
      default: return 1'b0;
    endcase
  endfunction
  // Random operand levels are trimmed to combinations a core can produce.
  function automatic peq_pkg::peq_operand_s legal(
    input peq_pkg::peq_operand_s o);
    o.op_bus_valid &= !(o.x_transfer_instruction && o.y_transfer_instruction);
    o.op_bus_xymem &= o.op_bus_valid;
    o.op_bus_ilmem &= o.op_bus_valid && !o.op_bus_xymem;
    o.cache_miss &= o.op_bus_valid && !o.op_bus_xymem && !o.op_bus_ilmem;
    o.op_bus_wait &= o.op_bus_valid;
    o.cache_preload_instruction &= o.cache_miss && !o.op_bus_write;
    o.write_through &= o.op_bus_write;
    o.miss_wait &= o.cache_miss && !o.cache_preload_instruction;
    return o;
  endfunction
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic clear();
    en = 1'b0;
    clr = 1'b1;
    tick();
    clr = 1'b0;
    en = 1'b1;
  endtask
  task automatic operand_round(input int c);
    peq_pkg::peq_operand_s o;
    ext = (c == 11);
    clear();
    for (int k = 0; k < 4; k++) begin
      sel[k] = 5'((c + 3 * k) % 12);
      want[k] = '0;
    end
    for (int j = 0; j < 80; j++) begin
      o = legal(j < 4 ? CORNER[j] : 14'($urandom));
      op = o;
      for (int k = 0; k < 4; k++) begin
        if (ev(sel[k], o) && !(ext && k[0])) want[k]++;
      end
      tick();
    end
    op = '0;
    repeat (3) tick();
    for (int k = 0; k < 4; k++) begin
      check("count", want[k], cnt[k]);
    end
    $display("operand round %0d done", c);
  endtask
  task automatic bus_round(input int i);
    int c0;
    int s0;
    logic [4:0] a;
    logic [4:0] b;
    ext = 1'b0;
    clear();
    c0 = n_cell[i];
    s0 = n_stall[i];
    a = peq_pkg::SEL_SYSBUS_ASK + 5'(i);
    b = peq_pkg::SEL_ASK_STALL + 5'(i);
    sel = '{a, b, a, b};
    run = 1'b1;
    repeat (400) tick();
    run = 1'b0;
    repeat (200) if (bus.ask || bus.reply) tick();
    repeat (12) tick();
    check("bus cells", 32'(n_cell[i] - c0), cnt[2]);
    check("bus stalls", 32'(n_stall[i] - s0), cnt[3]);
    check("low channels", 32'h0000_0000, cnt[0] | cnt[1]);
    $display("bus round %0d done", i);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 10000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'h2fbc1ab2));
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 rst_link = 1'b0;
    tick();
    for (int c = 0; c < 12; c++) operand_round(c);
    for (int i = 0; i < 2; i++) bus_round(i);
    conclude();
  end
endmodule // tb_perf_event_qualifier
bind peq_event_qualifier peq_qualifier_props props_u (.ref_clk_i, .sys_rst_i,
  .operand_i, .chan_sel_i, .extend_low_pair_i, .count_enable_i,
  .count_clear_i, .count_o, .event_pulse_o);
